/* File: core/xtal_osc_pkg.sv */
// Purpose: constants for crystal oscillator enable and load-capacitance trim control
// Assumes: register map reached through the device control interface (addr/data/strobe)
// Notes: factory trim codes from 11000 upward saturate in the effective outputs; readback returns the raw code
//
// Contract
// - the oscillator runs while xtal_osc_enable (bit 7) is 1 and is stopped while it is 0.
// - with override clear and strap low, the enable is forced to 0 and writes to it are ignored.
// - setting clock_lock_override removes the strap lock so enable writes take effect.
// - with strap high and override clear, the enable loads 1 on each strap rising edge, then accepts writes.
// - with override set the enable defaults to 1 regardless of strap and stays writable.
// - both factory cap fields sit in bits 4:0 of their own registers, are set automatically and read-only.
// - trim code 00000 means 14.0pF rising 0.5pF per step to 10111, codes 11000 and up read as 25.5pF.
// - the two cap adjust fields are 4-bit two's complement at bits 3:0 and 7:4, 0.5pF step, reset zero.
// - with override set every clocking control field, strap-locked ones included, is writable.
package xtal_osc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int TRIM_W = 5;
	localparam int ADJ_W = 4;
	localparam logic [ADDR_W-1:0] IN_CAP_READBACK_ADDR = 8'h73;
	localparam logic [ADDR_W-1:0] OUT_CAP_READBACK_ADDR = 8'h74;
	localparam logic [ADDR_W-1:0] LOAD_CAP_ADJUST_ADDR = 8'h77;
	localparam logic [ADDR_W-1:0] OSC_ENABLE_CTRL_ADDR = 8'h81;
	localparam int OSC_ENABLE_BIT = 7;
	localparam int IN_ADJ_LSB = 0;
	localparam int OUT_ADJ_LSB = 4;
	localparam logic [ADJ_W-1:0] ADJ_RESET = 4'h0;
	localparam logic [TRIM_W-1:0] TRIM_SAT_CODE = 5'h17;
	localparam logic [DATA_W-1:0] RESERVED_READ = 8'h00;
	localparam logic [DATA_W-2:0] ENABLE_CTRL_LOW_RESET = 7'h00;
	typedef enum logic [1:0] {lock_forced_off, lock_strap_default, lock_override} lock_mode_t;
endpackage

/* File: core/strap_edge_sync.sv */
// Purpose: two-stage synchroniser and rising-edge pulse for the boot strap pin
// Assumes: strap pin asynchronous to clk_sys
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module strap_edge_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	// pin and results
	input wire logic pin_async,
	output logic pin_level,
	output logic pin_rise
);
	logic meta_reg, meta_next;
	logic sync_reg, sync_next;
	logic prev_reg, prev_next;

	always_comb
	begin
		meta_next = meta_reg;
		sync_next = sync_reg;
		prev_next = prev_reg;
		if (clk_en)
		begin
			meta_next = pin_async;
			sync_next = meta_reg;
			prev_next = sync_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign pin_level = sync_reg;
	// edge counts only on clk_en cycles; prev resets to 0, so a pin high out of reset gives a rise
	assign pin_rise = clk_en & sync_reg & ~prev_reg;
endmodule
`default_nettype wire

/* File: core/crystal_osc_enable_trim.sv */
// Purpose: crystal oscillator enable with strap lock, factory trim readback and load-cap adjust
// Assumes: simple synchronous control port, write strobe one cycle, read data registered
// Notes: analogue oscillator lives outside; this drives its enable and trim codes
`timescale 1ns/100ps
`default_nettype none
module crystal_osc_enable_trim (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	// control interface
	input wire logic [xtal_osc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [xtal_osc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [xtal_osc_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// clocking configuration
	input wire logic boot_strap_pin,
	input wire logic clock_lock_override,
	// factory trim from fuses
	input wire logic [xtal_osc_pkg::TRIM_W-1:0] in_pin_factory_cap,
	input wire logic [xtal_osc_pkg::TRIM_W-1:0] out_pin_factory_cap,
	// analogue oscillator controls
	output logic osc_run,
	output logic [xtal_osc_pkg::ADJ_W-1:0] in_pin_cap_adjust,
	output logic [xtal_osc_pkg::ADJ_W-1:0] out_pin_cap_adjust,
	output logic [xtal_osc_pkg::TRIM_W-1:0] in_pin_cap_effective,
	output logic [xtal_osc_pkg::TRIM_W-1:0] out_pin_cap_effective
);
	import xtal_osc_pkg::*;

	logic strap_level, strap_rise;
	logic ovd_meta_reg, ovd_meta_next;
	logic ovd_reg, ovd_next;
	logic ovd_prev_reg, ovd_prev_next;
	logic enable_reg, enable_next;
	logic [DATA_W-2:0] ctrl_low_reg, ctrl_low_next;
	logic [ADJ_W-1:0] in_adj_reg, in_adj_next;
	logic [ADJ_W-1:0] out_adj_reg, out_adj_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [TRIM_W-1:0] in_trim_reg, in_trim_next;
	logic [TRIM_W-1:0] out_trim_reg, out_trim_next;
	logic enable_visible;
	lock_mode_t lock_mode;

	// saturate factory code, 11000 and above share the top value
	function automatic logic [TRIM_W-1:0] trim_clip(input logic [TRIM_W-1:0] code);
		trim_clip = (code > TRIM_SAT_CODE) ? TRIM_SAT_CODE : code;
	endfunction

	// adjust plus trim, clamped to field range; software should keep it in range anyway
	function automatic logic [TRIM_W-1:0] cap_sum(input logic [TRIM_W-1:0] trim, input logic [ADJ_W-1:0] adj);
		logic signed [TRIM_W+1:0] s;
		s = signed'({2'b00, trim}) + signed'({{(TRIM_W+2-ADJ_W){adj[ADJ_W-1]}}, adj});
		if (s < 0)
			cap_sum = '0;
		else if (s > signed'({2'b00, {TRIM_W{1'b1}}}))
			cap_sum = '1;
		else
			cap_sum = s[TRIM_W-1:0];
	endfunction

	strap_edge_sync u_strap (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.pin_async(boot_strap_pin),
		.pin_level(strap_level),
		.pin_rise(strap_rise)
	);

	// override comes from another config block, may be async; two flops first
	always_comb
	begin
		ovd_meta_next = ovd_meta_reg;
		ovd_next = ovd_reg;
		ovd_prev_next = ovd_prev_reg;
		if (clk_en)
		begin
			ovd_meta_next = clock_lock_override;
			ovd_next = ovd_meta_reg;
			ovd_prev_next = ovd_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ovd_meta_reg <= 1'b0;
			ovd_reg <= 1'b0;
			ovd_prev_reg <= 1'b0;
		end
		else
		begin
			ovd_meta_reg <= ovd_meta_next;
			ovd_reg <= ovd_next;
			ovd_prev_reg <= ovd_prev_next;
		end
	end

	always_comb
	begin
		if (ovd_reg)
			lock_mode = lock_override;
		else if (strap_level)
			lock_mode = lock_strap_default;
		else
			lock_mode = lock_forced_off;
	end

	// register writes and enable control
	always_comb
	begin
		enable_next = enable_reg;
		ctrl_low_next = ctrl_low_reg;
		in_adj_next = in_adj_reg;
		out_adj_next = out_adj_reg;
		if (clk_en)
		begin
			unique case (lock_mode)
				lock_forced_off:
					enable_next = 1'b0;
				lock_strap_default:
				begin
					if (strap_rise)
						enable_next = 1'b1;
					else if (reg_wr && reg_addr == OSC_ENABLE_CTRL_ADDR)
						enable_next = reg_wdata[OSC_ENABLE_BIT];
				end
				lock_override:
				begin
					// default 1 when override is raised
					if (!ovd_prev_reg)
						enable_next = 1'b1;
					else if (reg_wr && reg_addr == OSC_ENABLE_CTRL_ADDR)
						enable_next = reg_wdata[OSC_ENABLE_BIT];
				end
			endcase
			// neighbour bits written even when enable is locked
			if (reg_wr && reg_addr == OSC_ENABLE_CTRL_ADDR)
				ctrl_low_next = reg_wdata[DATA_W-2:0];
			if (reg_wr && reg_addr == LOAD_CAP_ADJUST_ADDR)
			begin
				in_adj_next = reg_wdata[IN_ADJ_LSB +: ADJ_W];
				out_adj_next = reg_wdata[OUT_ADJ_LSB +: ADJ_W];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			enable_reg <= 1'b0;
			ctrl_low_reg <= ENABLE_CTRL_LOW_RESET;
			in_adj_reg <= ADJ_RESET;
			out_adj_reg <= ADJ_RESET;
		end
		else
		begin
			enable_reg <= enable_next;
			ctrl_low_reg <= ctrl_low_next;
			in_adj_reg <= in_adj_next;
			out_adj_reg <= out_adj_next;
		end
	end

	// locked read shows forced value at once
	assign enable_visible = (lock_mode == lock_forced_off) ? 1'b0 : enable_reg;

	// read port and registered trim outputs
	always_comb
	begin
		rdata_next = rdata_reg;
		rvalid_next = rvalid_reg;
		// saturate, then add adjust
		// registered so the effective codes leave from flops
		in_trim_next = cap_sum(trim_clip(in_pin_factory_cap), in_adj_reg);
		out_trim_next = cap_sum(trim_clip(out_pin_factory_cap), out_adj_reg);
		if (clk_en)
		begin
			rvalid_next = reg_rd;
			if (reg_rd)
			begin
				unique case (reg_addr)
					IN_CAP_READBACK_ADDR:
						rdata_next = {{(DATA_W-TRIM_W){1'b0}}, in_pin_factory_cap};
					OUT_CAP_READBACK_ADDR:
						rdata_next = {{(DATA_W-TRIM_W){1'b0}}, out_pin_factory_cap};
					LOAD_CAP_ADJUST_ADDR:
						rdata_next = {out_adj_reg, in_adj_reg};
					OSC_ENABLE_CTRL_ADDR:
						rdata_next = {enable_visible, ctrl_low_reg};
					default:
						rdata_next = RESERVED_READ;
				endcase
			end
		end
		else
		begin
			in_trim_next = in_trim_reg;
			out_trim_next = out_trim_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_reg <= RESERVED_READ;
			rvalid_reg <= 1'b0;
			in_trim_reg <= '0;
			out_trim_reg <= '0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			in_trim_reg <= in_trim_next;
			out_trim_reg <= out_trim_next;
		end
	end

	// oscillator run follows the enable bit
	assign osc_run = enable_reg;
	assign in_pin_cap_adjust = in_adj_reg;
	assign out_pin_cap_adjust = out_adj_reg;
	assign in_pin_cap_effective = in_trim_reg;
	assign out_pin_cap_effective = out_trim_reg;
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
endmodule
`default_nettype wire

/* File: bench/crystal_osc_enable_trim_chk.sv */
// Purpose: port checker for crystal_osc_enable_trim
// Assumes: clk_en high while judged
// Notes: strap and override lag two flops
`timescale 1ns/100ps
`default_nettype none
module crystal_osc_enable_trim_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	// control port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// pins and trims
	input wire logic boot_strap_pin,
	input wire logic clock_lock_override,
	input wire logic [4:0] in_pin_factory_cap,
	input wire logic [4:0] out_pin_factory_cap,
	input wire logic osc_run,
	input wire logic [3:0] in_pin_cap_adjust,
	input wire logic [3:0] out_pin_cap_adjust
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	wire rd_ok = reg_rd & clk_en;
	wire wr_ok = reg_wr & clk_en;
	wire wr_adj = wr_ok & (reg_addr == 8'h77);
	AST_RVALID: assert property (rd_ok |=> reg_rvalid)
		else $error("read not answered");
	AST_IN_TRIM: assert property (rd_ok && reg_addr == 8'h73 |=> reg_rdata == {3'h0, $past(in_pin_factory_cap)})
		else $error("in trim readback wrong");
	AST_OUT_TRIM: assert property (rd_ok && reg_addr == 8'h74 |=> reg_rdata == {3'h0, $past(out_pin_factory_cap)})
		else $error("out trim readback wrong");
	AST_ADJ_WR: assert property (wr_adj |=> {out_pin_cap_adjust, in_pin_cap_adjust} == $past(reg_wdata))
		else $error("adjust write lost");
	AST_ADJ_HOLD: assert property (clk_en && !wr_adj |=> $stable({out_pin_cap_adjust, in_pin_cap_adjust}))
		else $error("adjust moved without write");
	// strap low, no override: forced off within the sync delay
	AST_LOCKED_OFF: assert property ((!boot_strap_pin && !clock_lock_override)[*5] |-> !osc_run)
		else $error("enable not forced off");
	AST_STRAP_ON: assert property ((!clock_lock_override)[*3] ##0 !boot_strap_pin ##1
		(boot_strap_pin && !clock_lock_override) |-> ##[1:5] osc_run)
		else $error("strap rise did not enable");
	AST_OVD_ON: assert property ($rose(clock_lock_override) |-> ##[1:5] osc_run)
		else $error("override did not enable");
	AST_UNLOCKED_WR: assert property (clock_lock_override[*6] ##0 (wr_ok && reg_addr == 8'h81)
		|=> osc_run == $past(reg_wdata[7]))
		else $error("unlocked enable write lost");
	cover property (wr_ok && reg_addr == 8'h81 && !boot_strap_pin && !clock_lock_override);
	cover property ($rose(osc_run));
	cover property (wr_adj);
endmodule
bind crystal_osc_enable_trim crystal_osc_enable_trim_chk u_chk (.clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .boot_strap_pin, .clock_lock_override, .in_pin_factory_cap,
	.out_pin_factory_cap, .osc_run, .in_pin_cap_adjust, .out_pin_cap_adjust);
`default_nettype wire

/* File: bench/xtal_model.sv */
// Purpose: behavioural crystal on the oscillator pins
// Assumes: osc_run starts and stops it
// Notes: wave stands still while stopped
`timescale 1ns/100ps
`default_nettype none
module xtal_model (
	// enable from the block
	input wire logic osc_run,
	// ringing seen by the bench
	output logic xtal_wave
);
	initial xtal_wave = 1'b0;
	always #20.8 if (osc_run === 1'b1) xtal_wave = ~xtal_wave;
endmodule
`default_nettype wire

/* File: bench/crystal_osc_enable_trim_tb.sv */
// Purpose: self-checking bench for crystal_osc_enable_trim
// Assumes: clk_en held high except in t_freeze
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("mismatch %0t %h %h", $time, a, b); end end
module crystal_osc_enable_trim_tb;
	import xtal_osc_pkg::*;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic boot_strap_pin = 1'b0;
	logic clock_lock_override = 1'b0;
	logic [4:0] in_pin_factory_cap = 5'h1a;
	logic [4:0] out_pin_factory_cap = 5'h0c;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic osc_run;
	logic [3:0] in_pin_cap_adjust;
	logic [3:0] out_pin_cap_adjust;
	logic [4:0] in_pin_cap_effective;
	logic [4:0] out_pin_cap_effective;
	logic xtal_wave;
	int failures = 0;
	int check_count = 0;
	always #4 clk_sys = ~clk_sys;
	crystal_osc_enable_trim crystal_osc_enable_trim_inst (.clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .boot_strap_pin, .clock_lock_override, .in_pin_factory_cap,
		.out_pin_factory_cap, .osc_run, .in_pin_cap_adjust, .out_pin_cap_adjust, .in_pin_cap_effective,
		.out_pin_cap_effective);
	xtal_model xtal_model_inst (.osc_run, .xtal_wave);
	task automatic summarize;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		for (int n = 0; n < 3; n++)
		begin
			@(negedge clk_sys);
			if (reg_rvalid === 1'b1)
			begin
				`CHK(reg_rdata, e)
				return;
			end
		end
		failures++;
		summarize();
	endtask
	// edges counted, parity alone could hide a running crystal
	task automatic wave(input logic e);
		int t;
		logic w;
		t = 0;
		w = xtal_wave;
		repeat (20)
		begin
			@(posedge clk_sys);
			if (xtal_wave !== w)
				t++;
			w = xtal_wave;
		end
		`CHK(t > 0, e)
	endtask
	task automatic t_regs;
		rd(8'h77, 8'h00);
		rd(8'h81, 8'h00);
		rd(8'h73, 8'h1a);
		wr(8'h74, 8'hff);
		rd(8'h74, 8'h0c);
		rd(8'h50, RESERVED_READ);
		wr(8'h77, 8'h8c);
		rd(8'h77, 8'h8c);
		`CHK({out_pin_cap_adjust, in_pin_cap_adjust}, 8'h8c)
		`CHK(in_pin_cap_effective, TRIM_SAT_CODE - 5'h4)
		`CHK(out_pin_cap_effective, 5'h04)
	endtask
	// frozen enable drops a write
	task automatic t_freeze;
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(8'h77, 8'h00);
		`CHK({out_pin_cap_adjust, in_pin_cap_adjust}, 8'h8c)
		@(posedge clk_sys);
		clk_en <= 1'b1;
	endtask
	// strap high through reset counts as a rise
	task automatic t_reset;
		@(posedge clk_sys);
		arst_n <= 1'b0;
		boot_strap_pin <= 1'b1;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (6) @(negedge clk_sys);
		`CHK(osc_run, 1'b1)
		rd(8'h81, 8'h80);
		rd(8'h77, 8'h00);
	endtask
	task automatic t_lock;
		wr(8'h81, 8'hff);
		rd(8'h81, 8'h7f);
		`CHK(osc_run, 1'b0)
		wave(1'b0);
	endtask
	task automatic t_strap;
		@(posedge clk_sys);
		boot_strap_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(8'h81, 8'hff);
		wave(1'b1);
		wr(8'h81, 8'h01);
		rd(8'h81, 8'h01);
		`CHK(osc_run, 1'b0)
	endtask
	task automatic t_ovd;
		@(posedge clk_sys);
		boot_strap_pin <= 1'b0;
		clock_lock_override <= 1'b1;
		repeat (6) @(negedge clk_sys);
		`CHK(osc_run, 1'b1)
		wr(8'h81, 8'h00);
		`CHK(osc_run, 1'b0)
		wr(8'h81, 8'h80);
		`CHK(osc_run, 1'b1)
		@(posedge clk_sys);
		clock_lock_override <= 1'b0;
		repeat (6) @(negedge clk_sys);
		`CHK(osc_run, 1'b0)
		rd(8'h81, 8'h00);
	endtask
	initial
	begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_regs();
		t_freeze();
		t_lock();
		t_strap();
		t_ovd();
		t_reset();
		summarize();
	end
endmodule
`default_nettype wire
